/* File: fobx_map.svh */
// Offsets, field positions, reset values and opcodes of the file-op executor
`ifndef FOBX_MAP_SVH
`define FOBX_MAP_SVH

// Register byte offsets
`define FOBX_OFS_INSTR      8'h00
`define FOBX_OFS_ACCUM      8'h04
`define FOBX_OFS_STATUS     8'h08
`define FOBX_OFS_PC         8'h0C
`define FOBX_OFS_PAGE       8'h10
`define FOBX_OFS_FPTR       8'h14
`define FOBX_OFS_FDATA      8'h18
`define FOBX_OFS_CYCLES     8'h1C

// Status field positions
`define FOBX_ST_ZERO        0
`define FOBX_ST_SKIP        1

// Instruction word fields
`define FOBX_IW_W           14
`define FOBX_FA_W           7
`define FOBX_DEST_BIT       7
`define FOBX_OPC6_HI        13
`define FOBX_OPC6_LO        8
`define FOBX_OPC3_HI        13
`define FOBX_OPC3_LO        11
`define FOBX_JMP_K_W        11

// Opcode values
`define FOBX_OPC_INVERT     6'h09
`define FOBX_OPC_DEC        6'h03
`define FOBX_OPC_INC        6'h0A
`define FOBX_OPC_DEC_SKIP   6'h0B
`define FOBX_OPC_INC_SKIP   6'h0F
`define FOBX_OPC_JUMP       3'h5

// Jump page latch bits feeding the counter top
`define FOBX_PAGE_HI        4
`define FOBX_PAGE_LO        3

// Widths and reset values
`define FOBX_PC_W           13
`define FOBX_FILE_DEPTH     128
`define FOBX_RST_PC         13'h0000
`define FOBX_RST_BYTE       8'h00
`define FOBX_RST_WORD       32'h0000_0000
`define FOBX_RST_INSTR      14'h0000

`endif

/* File: fobx_pkg.sv */
// Types shared by the file-op executor and its decoder
package fobx_pkg;

	// Operation kinds
	typedef enum logic [2:0] {
		FOBX_K_IDLE,
		FOBX_K_INVERT,
		FOBX_K_DEC,
		FOBX_K_INC,
		FOBX_K_DEC_SKIP,
		FOBX_K_INC_SKIP,
		FOBX_K_JUMP
	} fobx_kind_t;

	// Decoded result of one instruction
	typedef struct packed {
		fobx_kind_t  kind;
		logic [6:0]  faddr;
		logic        wr_accum;
		logic        wr_file;
		logic [7:0]  value;
		logic        upd_zero;
		logic        zero;
		logic        skip;
		logic        jump;
		logic [10:0] target;
	} fobx_res_t;

endpackage

/* File: fobx_alu.sv */
// Decoder and arithmetic for the file ops and the absolute jump
`timescale 1ns/1ps
`include "fobx_map.svh"

module fobx_alu (
	input  wire logic [13:0]       instr,
	input  wire logic [7:0]        file_val,
	output fobx_pkg::fobx_res_t    res
);

	logic [5:0] opc6;
	logic [2:0] opc3;
	logic       dest;
	fobx_pkg::fobx_kind_t kind;

	// Operand fields
	assign opc6 = instr[`FOBX_OPC6_HI:`FOBX_OPC6_LO];
	assign opc3 = instr[`FOBX_OPC3_HI:`FOBX_OPC3_LO];
	assign dest = instr[`FOBX_DEST_BIT];

	// Kind decode
	always_comb begin
		if (opc3 == `FOBX_OPC_JUMP) begin
			kind = fobx_pkg::FOBX_K_JUMP;
		end else begin
			unique case (opc6)
				`FOBX_OPC_INVERT:   kind = fobx_pkg::FOBX_K_INVERT;
				`FOBX_OPC_DEC:      kind = fobx_pkg::FOBX_K_DEC;
				`FOBX_OPC_INC:      kind = fobx_pkg::FOBX_K_INC;
				`FOBX_OPC_DEC_SKIP: kind = fobx_pkg::FOBX_K_DEC_SKIP;
				`FOBX_OPC_INC_SKIP: kind = fobx_pkg::FOBX_K_INC_SKIP;
				default:            kind = fobx_pkg::FOBX_K_IDLE;
			endcase
		end
	end

	// Result, destination, flag and skip
	always_comb begin
		res          = '0;
		res.kind     = kind;
		res.faddr    = instr[`FOBX_FA_W-1:0];
		res.target   = instr[`FOBX_JMP_K_W-1:0];
		unique case (kind)
			fobx_pkg::FOBX_K_INVERT: begin
				res.value    = ~file_val;
				res.upd_zero = 1'b1;
			end
			fobx_pkg::FOBX_K_DEC: begin
				res.value    = file_val - 8'h01;
				res.upd_zero = 1'b1;
			end
			fobx_pkg::FOBX_K_INC: begin
				res.value    = file_val + 8'h01;
				res.upd_zero = 1'b1;
			end
			fobx_pkg::FOBX_K_DEC_SKIP: begin
				res.value    = file_val - 8'h01;
			end
			fobx_pkg::FOBX_K_INC_SKIP: begin
				res.value    = file_val + 8'h01;
			end
			fobx_pkg::FOBX_K_JUMP: begin
				res.jump     = 1'b1;
			end
			fobx_pkg::FOBX_K_IDLE: begin
				res.value    = 8'h00;
			end
		endcase
		res.zero     = (res.value == 8'h00);
		if (kind != fobx_pkg::FOBX_K_JUMP &&
		    kind != fobx_pkg::FOBX_K_IDLE) begin
			res.wr_accum = ~dest;
			res.wr_file  = dest;
		end
		res.skip = (kind == fobx_pkg::FOBX_K_DEC_SKIP ||
		            kind == fobx_pkg::FOBX_K_INC_SKIP) &&
		           res.zero;
	end

endmodule // fobx_alu

/* File: fobx_exec.sv */
// File-op and absolute-jump executor with a classic Wishbone slave
//
// The Wishbone interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "fobx_map.svh"

module fobx_exec (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o
);

	////////////////////////////////////////////////////////////////////////
	// Helpers

	// Byte-lane merge of a write into an old word
	function automatic logic [31:0] lane_merge(
		input logic [31:0] old_w,
		input logic [31:0] new_w,
		input logic [3:0]  sel
	);
		logic [31:0] m;
		m = old_w;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				m[i*8 +: 8] = new_w[i*8 +: 8];
			end
		end
		return m;
	endfunction

	// Address hit on a register
	function automatic logic hit(
		input logic [7:0] adr,
		input logic [7:0] ofs
	);
		return adr == ofs;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// State

	logic [7:0]                 file_mem [`FOBX_FILE_DEPTH];
	logic [`FOBX_PC_W-1:0]      pc_q;
	logic [7:0]                 accum_q;
	logic                       zero_q;
	logic                       squash_q;
	logic [7:0]                 page_q;
	logic [6:0]                 fptr_q;
	logic [`FOBX_IW_W-1:0]      instr_q;
	logic [31:0]                cycles_q;
	logic                       ack_q;
	logic [31:0]                rdata_q;

	logic                       req;
	logic                       wr_req;
	logic                       issue;
	logic                       live;
	logic [`FOBX_IW_W-1:0]      instr_new;
	logic [31:0]                instr_mrg;
	logic [7:0]                 file_rd;
	fobx_pkg::fobx_res_t        res;

	////////////////////////////////////////////////////////////////////////
	// Bus request decode

	// New request only when no answer is standing
	assign req    = wb_cyc_i & wb_stb_i & ~ack_q;
	assign wr_req = req & wb_we_i;

	// A write to the instruction register is one instruction cycle
	assign instr_mrg = lane_merge({18'h0, instr_q}, wb_dat_i, wb_sel_i);
	assign instr_new = instr_mrg[`FOBX_IW_W-1:0];
	assign issue = wr_req & hit(wb_adr_i, `FOBX_OFS_INSTR) &
	               (wb_sel_i[1:0] != 2'b00);

	// Squashed slot executes as an idle slot
	assign live = issue & ~squash_q;

	// Operand fetch from the file array
	assign file_rd = file_mem[instr_new[`FOBX_FA_W-1:0]];

	fobx_alu u_alu (
		.instr    (instr_new),
		.file_val (file_rd),
		.res      (res)
	);

	////////////////////////////////////////////////////////////////////////
	// Execution

	// Last issued instruction word
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			instr_q <= `FOBX_RST_INSTR;
		end else if (issue) begin
			instr_q <= instr_new;
		end
	end

	// Program counter: step, or jump target with page bits
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pc_q <= `FOBX_RST_PC;
		end else if (live && res.jump) begin
			pc_q <= {page_q[`FOBX_PAGE_HI:`FOBX_PAGE_LO],
			         res.target};
		end else if (issue) begin
			pc_q <= pc_q + `FOBX_PC_W'(1);
		end
	end

	// Next slot is discarded after a taken skip or a jump
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			squash_q <= 1'b0;
		end else if (issue) begin
			squash_q <= live & (res.skip | res.jump);
		end
	end

	// Accumulator: result, or software write
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			accum_q <= `FOBX_RST_BYTE;
		end else if (live && res.wr_accum) begin
			accum_q <= res.value;
		end else if (wr_req && hit(wb_adr_i, `FOBX_OFS_ACCUM) &&
		             wb_sel_i[0]) begin
			accum_q <= wb_dat_i[7:0];
		end
	end

	// Zero flag: ops that update it, or software write
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			zero_q <= 1'b0;
		end else if (live && res.upd_zero) begin
			zero_q <= res.zero;
		end else if (wr_req && hit(wb_adr_i, `FOBX_OFS_STATUS) &&
		             wb_sel_i[0]) begin
			zero_q <= wb_dat_i[`FOBX_ST_ZERO];
		end
	end

	// File array: result write-back, or software write at pointer
	always_ff @(posedge ref_clk) begin
		if (live && res.wr_file) begin
			file_mem[res.faddr] <= res.value;
		end else if (wr_req && hit(wb_adr_i, `FOBX_OFS_FDATA) &&
		             wb_sel_i[0]) begin
			file_mem[fptr_q] <= wb_dat_i[7:0];
		end
	end

	// Jump page latch
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			page_q <= `FOBX_RST_BYTE;
		end else if (wr_req && hit(wb_adr_i, `FOBX_OFS_PAGE) &&
		             wb_sel_i[0]) begin
			page_q <= wb_dat_i[7:0];
		end
	end

	// File pointer for software access
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			fptr_q <= 7'h00;
		end else if (wr_req && hit(wb_adr_i, `FOBX_OFS_FPTR) &&
		             wb_sel_i[0]) begin
			fptr_q <= wb_dat_i[6:0];
		end
	end

	// Instruction cycles issued, squashed slots included
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cycles_q <= `FOBX_RST_WORD;
		end else if (issue) begin
			cycles_q <= cycles_q + 32'h0000_0001;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bus answer

	// One-cycle acknowledge, dropped the cycle after
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req;
		end
	end

	// Read data captured with the request; unmapped reads zero
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rdata_q <= `FOBX_RST_WORD;
		end else if (req && !wb_we_i) begin
			unique case (wb_adr_i)
				`FOBX_OFS_INSTR:  rdata_q <= {18'h0, instr_q};
				`FOBX_OFS_ACCUM:  rdata_q <= {24'h0, accum_q};
				`FOBX_OFS_STATUS: rdata_q <= {30'h0, squash_q, zero_q};
				`FOBX_OFS_PC:     rdata_q <= {19'h0, pc_q};
				`FOBX_OFS_PAGE:   rdata_q <= {24'h0, page_q};
				`FOBX_OFS_FPTR:   rdata_q <= {25'h0, fptr_q};
				`FOBX_OFS_FDATA:  rdata_q <= {24'h0, file_mem[fptr_q]};
				`FOBX_OFS_CYCLES: rdata_q <= cycles_q;
				default:          rdata_q <= `FOBX_RST_WORD;
			endcase
		end
	end

	// Outputs
	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdata_q;

endmodule // fobx_exec

/* File: fobx_exec_monitor.sv */
// Bus timing and register shape checks for the file-op executor
`timescale 1ns/1ps
module fobx_exec_chk (
	input wire logic        ref_clk,
	input wire logic        rst,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	logic rd_ack;
	logic req;
	// Read answer and pending request
	assign rd_ack = wb_cyc_i && wb_stb_i && !wb_we_i && wb_ack_o;
	assign req    = wb_cyc_i && wb_stb_i;
	ack_follows_req_a: assert property (req && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered next cycle");
	ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	ack_needs_req_a: assert property (!req |=> !wb_ack_o)
		else $error("ack without request");
	accum_shape_a: assert property (
		rd_ack && wb_adr_i == 8'h04 |-> wb_dat_o[31:8] == 24'h0)
		else $error("accumulator read has high bits");
	status_shape_a: assert property (
		rd_ack && wb_adr_i == 8'h08 |-> wb_dat_o[31:2] == 30'h0)
		else $error("status read has high bits");
	pc_shape_a: assert property (
		rd_ack && wb_adr_i == 8'h0C |-> wb_dat_o[31:13] == 19'h0)
		else $error("counter wider than thirteen bits");
	fptr_shape_a: assert property (
		rd_ack && wb_adr_i == 8'h14 |-> wb_dat_o[31:7] == 25'h0)
		else $error("file address wider than seven bits");
	unmapped_zero_a: assert property (
		rd_ack && wb_adr_i > 8'h1C |-> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
endmodule // fobx_exec_chk

bind fobx_exec fobx_exec_chk chk_u (.ref_clk(ref_clk), .rst(rst),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

/* File: tb_top.sv */
// Random and corner-case bench for the file-op executor
`timescale 1ns/1ps
`include "fobx_map.svh"
module tb_top;
	logic        ref_clk = 1'b0;
	logic        rst = 1'b1;
	logic        req = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] dat = 32'h0;
	logic [31:0] dat_o;
	logic        ack;
	int          errors = 0;
	int          samples_checked = 0;
	logic [12:0] pc = 13'h0;
	logic [5:0]  opc [5] = '{`FOBX_OPC_INVERT, `FOBX_OPC_DEC, `FOBX_OPC_INC,
		`FOBX_OPC_DEC_SKIP, `FOBX_OPC_INC_SKIP};
	logic [7:0]  crn [3] = '{8'h01, 8'hFF, 8'h00};

	// Clock
	always #2 ref_clk = ~ref_clk;

	fobx_exec dut_u (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(req),
		.wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
		.wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack));

	////////////////////////////////////////////////////////////////////////
	// One classic cycle, held until ack, then one idle cycle
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		req <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge ref_clk);
		end while (ack !== 1'b1);
		q = dat_o;
		req <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			errors++;
			$display("wrong value at %0t: got %h want %h", $time, s, e);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		wb(1'b0, a, 32'h0, q);
		chk(q, e);
	endtask

	task automatic close_out;
		$display("checks %0d, mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Watchdog
	initial begin
		repeat (20000) @(posedge ref_clk);
		errors++;
		close_out;
	end

	// Main sequence
	initial begin
		int         i;
		int         k;
		logic [6:0] f;
		logic       d;
		logic       sk;
		logic       z0;
		logic       ez;
		logic [7:0] v;
		logic [7:0] a0;
		logic [7:0] r;
		logic [7:0] pg;
		logic [10:0] kk;
		void'($urandom(93961));
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		rd(`FOBX_OFS_PC, 32'h0);
		rd(`FOBX_OFS_STATUS, 32'h0);
		// File ops, corners first then random
		for (i = 0; i < 60; i++) begin
			k = (i < 15) ? i % 5 : $urandom_range(4);
			v = (i < 15) ? crn[i / 5] : 8'($urandom);
			f = 7'($urandom);
			d = 1'($urandom);
			a0 = 8'($urandom);
			z0 = 1'($urandom);
			wr(`FOBX_OFS_FPTR, {25'h0, f});
			wr(`FOBX_OFS_FDATA, {24'h0, v});
			wr(`FOBX_OFS_ACCUM, {24'h0, a0});
			wr(`FOBX_OFS_STATUS, {31'h0, z0});
			wr(`FOBX_OFS_INSTR, {18'h0, opc[k], d, f});
			pc = pc + 13'h1;
			r = (k == 0) ? ~v : (k == 1 || k == 3) ? v - 8'h01 : v + 8'h01;
			sk = k > 2 && r == 8'h00;
			ez = (k < 3) ? r == 8'h00 : z0;
			rd(`FOBX_OFS_ACCUM, d ? a0 : r);
			rd(`FOBX_OFS_FDATA, d ? r : v);
			rd(`FOBX_OFS_STATUS, {30'h0, sk, ez});
			if (sk) begin
				wr(`FOBX_OFS_INSTR, {18'h0, opc[2], 1'b0, f});
				pc = pc + 13'h1;
				rd(`FOBX_OFS_ACCUM, d ? a0 : r);
				rd(`FOBX_OFS_STATUS, {31'h0, ez});
			end
			rd(`FOBX_OFS_PC, {19'h0, pc});
		end
		$display("file op test done");
		// Absolute jump, widest immediate first
		for (i = 0; i < 6; i++) begin
			pg = 8'($urandom);
			kk = (i == 0) ? 11'h7FF : 11'($urandom);
			z0 = 1'($urandom);
			a0 = 8'($urandom);
			wr(`FOBX_OFS_PAGE, {24'h0, pg});
			wr(`FOBX_OFS_STATUS, {31'h0, z0});
			wr(`FOBX_OFS_ACCUM, {24'h0, a0});
			wr(`FOBX_OFS_INSTR, {18'h0, `FOBX_OPC_JUMP, kk});
			pc = {pg[4:3], kk};
			rd(`FOBX_OFS_PC, {19'h0, pc});
			rd(`FOBX_OFS_STATUS, {30'h1, z0});
			wr(`FOBX_OFS_INSTR, {18'h0, opc[0], 8'h00});
			pc = pc + 13'h1;
			rd(`FOBX_OFS_ACCUM, {24'h0, a0});
			rd(`FOBX_OFS_PC, {19'h0, pc});
		end
		$display("jump test done");
		rd(8'h20, 32'h0);
		rd(8'hFC, 32'h0);
		$display("unmapped test done");
		close_out;
	end
endmodule // tb_top
